// [include/prtw_cfg.svh]
// Constants of the pressure/temperature window and extreme register bank.
// Assumes an 8-bit register space reached over a two-wire serial port.
//
// Notes on behaviour
// - Pressure window is unsigned 16 bits, metres/2Pa.
// - Temperature window is unsigned 8-bit whole degrees.
// - Pressure minimum kept, three host read/write bytes.
// - Pressure maximum kept, three host read/write bytes.
// - Height mode extremes: signed, four fraction bits.
// - Pressure mode extremes: unsigned, two fraction bits.
// - Temperature minimum and maximum, two bytes each.
// - Temperature extremes signed, four fraction bits.
// - Extremes zero at reset; host clears writing zero.
// - Mode bit zero pressure, one height.
// - Run bit one active, zero standby.
// - One-shot starts measurement; standby clears it after.
`ifndef PRTW_CFG_SVH
`define PRTW_CFG_SVH

// Register offsets
`define PRTW_ADDR_PWND_HI 8'h19
`define PRTW_ADDR_PWND_LO 8'h1a
`define PRTW_ADDR_TWND 8'h1b
`define PRTW_ADDR_PMIN_H 8'h1c
`define PRTW_ADDR_PMIN_M 8'h1d
`define PRTW_ADDR_PMIN_L 8'h1e
`define PRTW_ADDR_TMIN_H 8'h1f
`define PRTW_ADDR_TMIN_L 8'h20
`define PRTW_ADDR_PMAX_H 8'h21
`define PRTW_ADDR_PMAX_M 8'h22
`define PRTW_ADDR_PMAX_L 8'h23
`define PRTW_ADDR_TMAX_H 8'h24
`define PRTW_ADDR_TMAX_L 8'h25
`define PRTW_ADDR_CTRL 8'h26

// Control register fields
`define PRTW_CTRL_HEIGHT 7
`define PRTW_CTRL_OVS_HI 5
`define PRTW_CTRL_OVS_LO 3
`define PRTW_CTRL_RST 2
`define PRTW_CTRL_SHOT 1
`define PRTW_CTRL_RUN 0

// Reset values and bus constants
`define PRTW_REG_RESET 8'h00
`define PRTW_I2C_DEV_ADDR 7'h2a
`define PRTW_PRESS_W 20
`define PRTW_TEMP_W 12
`define PRTW_BITS_PER_BYTE 4'h8

`endif

// [include/prtw_pkg.sv]
// Types shared by the register bank modules.
// Assumes nothing of its surroundings.
`default_nettype none
package prtw_pkg;

	typedef logic [7:0] prtw_byte_t;

	// Serial port slave states
	typedef enum logic [3:0] {
		PRTW_IDLE = 4'b0000,
		PRTW_ADDR = 4'b0001,
		PRTW_AACK = 4'b0010,
		PRTW_REG = 4'b0011,
		PRTW_RACK = 4'b0100,
		PRTW_WR = 4'b0101,
		PRTW_WACK = 4'b0110,
		PRTW_RD = 4'b0111,
		PRTW_RDACK = 4'b1000
	} prtw_i2c_state_t;

endpackage
`default_nettype wire

// [include/prtw_cap_if.sv]
// Link between the register bank and one extreme capture slice.
// Assumes the bank drives samples and host writes, the slice the value.
`timescale 1ns/100ps
`default_nettype none
interface prtw_cap_if #(parameter int W = 20);
	logic clr;
	logic smp_vld;
	logic [W-1:0] smp;
	logic signed_cmp;
	logic wr_en;
	logic [1:0] wr_idx;
	logic [7:0] wr_data;
	logic [W-1:0] value;

	modport cap (
		input clr, smp_vld, smp, signed_cmp, wr_en, wr_idx, wr_data,
		output value
	);
	modport ctl (
		output clr, smp_vld, smp, signed_cmp, wr_en, wr_idx, wr_data,
		input value
	);
endinterface
`default_nettype wire

// [rtl/prtw_extreme.sv]
// One captured extreme (minimum or maximum) with byte-wise host access.
// Assumes byte index 0 is the most significant byte, value left aligned.
`timescale 1ns/100ps
`default_nettype none
module prtw_extreme #(
	parameter int W = 20,
	parameter bit IS_MAX = 1'b0
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	prtw_cap_if.cap c
);

	localparam int NB = (W + 7) / 8;
	localparam int PW = NB * 8;

	logic [W-1:0] val_reg;
	logic [W-1:0] wr_next;
	logic [PW-1:0] pad;
	logic better;

	////////////////////////////////////////////////////////////////////////
	// Host byte write; unused low bits of the last byte fall away
	always_comb begin
		pad = {val_reg, {(PW-W){1'b0}}};
		for (int i = 0; i < NB; i++) begin
			if (c.wr_idx == 2'(i)) begin
				pad[PW-1-8*i -: 8] = c.wr_data;
			end
		end
		wr_next = pad[PW-1 -: W];
	end

	// Signed compare when signed_cmp is set (height mode, or always for temperature), else unsigned
	always_comb begin
		if (c.signed_cmp) begin
			better = IS_MAX ? ($signed(c.smp) > $signed(val_reg)) :
				($signed(c.smp) < $signed(val_reg));
		end else begin
			better = IS_MAX ? (c.smp > val_reg) : (c.smp < val_reg);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Cleared slot takes the first result, so a zeroed minimum still tracks
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			val_reg <= '0;
		end else if (c.clr) begin
			val_reg <= '0;
		end else if (c.wr_en) begin
			val_reg <= wr_next;
		end else if (c.smp_vld && (better || val_reg == '0)) begin
			val_reg <= c.smp;
		end
	end

	assign c.value = val_reg;

endmodule // prtw_extreme
`default_nettype wire

// [rtl/prtw_regs.sv]
// Window, extreme and primary control registers behind a two-wire port.
// Assumes the measurement engine pulses meas_valid_i with both results,
// and that SCL/SDA arrive already synchronous to mclk_i.
`timescale 1ns/100ps
`default_nettype none
`include "prtw_cfg.svh"
module prtw_regs #(
	parameter int PRESS_W = `PRTW_PRESS_W,
	parameter int TEMP_W = `PRTW_TEMP_W,
	// Bus address; value arbitrary
	parameter logic [6:0] DEV_ADDR = `PRTW_I2C_DEV_ADDR
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic meas_valid_i,
	input wire logic [PRESS_W-1:0] press_res_i,
	input wire logic [TEMP_W-1:0] temp_res_i,
	output logic meas_start_o,
	output logic run_o,
	output logic awake_o,
	output logic height_mode_o,
	output logic [2:0] oversample_o,
	output logic [15:0] press_window_o,
	output logic [7:0] temp_window_o,
	output logic soft_reset_o
);

	////////////////////////////////////////////////////////////////////////
	// Declarations
	logic scl_q;
	logic sda_q;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	prtw_pkg::prtw_i2c_state_t st_reg;
	logic [3:0] cnt_reg;
	prtw_pkg::prtw_byte_t shift_reg;
	prtw_pkg::prtw_byte_t ptr_reg;
	prtw_pkg::prtw_byte_t rd_byte;
	logic rw_reg;
	logic mack_reg;
	logic oe_reg;
	logic wr_pls_reg;
	prtw_pkg::prtw_byte_t wr_addr_reg;
	prtw_pkg::prtw_byte_t wr_data_reg;
	logic [15:0] pwnd_reg;
	prtw_pkg::prtw_byte_t twnd_reg;
	logic height_reg;
	logic [2:0] ovs_reg;
	logic shot_reg;
	logic run_reg;
	logic srst_reg;
	logic start_reg;
	logic ctrl_wr;
	logic [23:0] pmin_pad;
	logic [23:0] pmax_pad;
	logic [15:0] tmin_pad;
	logic [15:0] tmax_pad;

	prtw_cap_if #(.W(PRESS_W)) pmin_if ();
	prtw_cap_if #(.W(PRESS_W)) pmax_if ();
	prtw_cap_if #(.W(TEMP_W)) tmin_if ();
	prtw_cap_if #(.W(TEMP_W)) tmax_if ();

	////////////////////////////////////////////////////////////////////////
	// Line sampling and bus condition detection
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_i;
			sda_q <= sda_i;
		end
	end

	// Data may only change while SCL is low, so a change with SCL high frames
	assign scl_rise = scl_i & ~scl_q;
	assign scl_fall = ~scl_i & scl_q;
	assign start_cond = scl_i & scl_q & sda_q & ~sda_i;
	assign stop_cond = scl_i & scl_q & ~sda_q & sda_i;

	////////////////////////////////////////////////////////////////////////
	// Read data selection by register pointer
	assign pmin_pad = {pmin_if.value, {(24-PRESS_W){1'b0}}};
	assign pmax_pad = {pmax_if.value, {(24-PRESS_W){1'b0}}};
	assign tmin_pad = {tmin_if.value, {(16-TEMP_W){1'b0}}};
	assign tmax_pad = {tmax_if.value, {(16-TEMP_W){1'b0}}};

	always_comb begin
		if (ptr_reg == `PRTW_ADDR_PWND_HI) begin
			rd_byte = pwnd_reg[15:8];
		end else if (ptr_reg == `PRTW_ADDR_PWND_LO) begin
			rd_byte = pwnd_reg[7:0];
		end else if (ptr_reg == `PRTW_ADDR_TWND) begin
			rd_byte = twnd_reg;
		end else if (ptr_reg == `PRTW_ADDR_PMIN_H) begin
			rd_byte = pmin_pad[23:16];
		end else if (ptr_reg == `PRTW_ADDR_PMIN_M) begin
			rd_byte = pmin_pad[15:8];
		end else if (ptr_reg == `PRTW_ADDR_PMIN_L) begin
			rd_byte = pmin_pad[7:0];
		end else if (ptr_reg == `PRTW_ADDR_TMIN_H) begin
			rd_byte = tmin_pad[15:8];
		end else if (ptr_reg == `PRTW_ADDR_TMIN_L) begin
			rd_byte = tmin_pad[7:0];
		end else if (ptr_reg == `PRTW_ADDR_PMAX_H) begin
			rd_byte = pmax_pad[23:16];
		end else if (ptr_reg == `PRTW_ADDR_PMAX_M) begin
			rd_byte = pmax_pad[15:8];
		end else if (ptr_reg == `PRTW_ADDR_PMAX_L) begin
			rd_byte = pmax_pad[7:0];
		end else if (ptr_reg == `PRTW_ADDR_TMAX_H) begin
			rd_byte = tmax_pad[15:8];
		end else if (ptr_reg == `PRTW_ADDR_TMAX_L) begin
			rd_byte = tmax_pad[7:0];
		end else if (ptr_reg == `PRTW_ADDR_CTRL) begin
			// Reset bit and bit 6 always read back as zero
			rd_byte = {height_reg, 1'b0, ovs_reg, 1'b0, shot_reg, run_reg};
		end else begin
			rd_byte = 8'h00; // Unmapped reads zero
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Serial slave: samples on SCL rise, drives SDA after SCL fall.
	// Pointer auto-increments, so bursts walk through the map in order.
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_reg <= prtw_pkg::PRTW_IDLE;
			cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			ptr_reg <= 8'h00;
			rw_reg <= 1'b0;
			mack_reg <= 1'b0;
			oe_reg <= 1'b0;
			wr_pls_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			wr_data_reg <= 8'h00;
		end else begin
			wr_pls_reg <= 1'b0;
			if (srst_reg) begin
				// Soft reset also drops the bus to avoid corrupt transfers
				st_reg <= prtw_pkg::PRTW_IDLE;
				cnt_reg <= 4'h0;
				ptr_reg <= 8'h00;
				oe_reg <= 1'b0;
			end else if (stop_cond) begin
				st_reg <= prtw_pkg::PRTW_IDLE;
				oe_reg <= 1'b0;
			end else if (start_cond) begin
				st_reg <= prtw_pkg::PRTW_ADDR;
				cnt_reg <= 4'h0;
				oe_reg <= 1'b0;
			end else if (scl_rise) begin
				case (st_reg)
					prtw_pkg::PRTW_ADDR, prtw_pkg::PRTW_REG, prtw_pkg::PRTW_WR: begin
						shift_reg <= {shift_reg[6:0], sda_i};
						cnt_reg <= cnt_reg + 4'h1;
					end
					prtw_pkg::PRTW_RD: begin
						cnt_reg <= cnt_reg + 4'h1;
					end
					prtw_pkg::PRTW_RDACK: begin
						mack_reg <= ~sda_i;
					end
					default: begin
					end
				endcase
			end else if (scl_fall) begin
				case (st_reg)
					prtw_pkg::PRTW_ADDR: begin
						if (cnt_reg == `PRTW_BITS_PER_BYTE) begin
							if (shift_reg[7:1] == DEV_ADDR) begin
								rw_reg <= shift_reg[0];
								oe_reg <= 1'b1;
								st_reg <= prtw_pkg::PRTW_AACK;
							end else begin
								st_reg <= prtw_pkg::PRTW_IDLE;
							end
						end
					end
					prtw_pkg::PRTW_AACK: begin
						cnt_reg <= 4'h0;
						if (rw_reg) begin
							shift_reg <= rd_byte;
							oe_reg <= ~rd_byte[7];
							st_reg <= prtw_pkg::PRTW_RD;
						end else begin
							oe_reg <= 1'b0;
							st_reg <= prtw_pkg::PRTW_REG;
						end
					end
					prtw_pkg::PRTW_REG: begin
						if (cnt_reg == `PRTW_BITS_PER_BYTE) begin
							ptr_reg <= shift_reg;
							oe_reg <= 1'b1;
							st_reg <= prtw_pkg::PRTW_RACK;
						end
					end
					prtw_pkg::PRTW_RACK, prtw_pkg::PRTW_WACK: begin
						cnt_reg <= 4'h0;
						oe_reg <= 1'b0;
						st_reg <= prtw_pkg::PRTW_WR;
					end
					prtw_pkg::PRTW_WR: begin
						if (cnt_reg == `PRTW_BITS_PER_BYTE) begin
							wr_pls_reg <= 1'b1;
							wr_addr_reg <= ptr_reg;
							wr_data_reg <= shift_reg;
							ptr_reg <= ptr_reg + 8'h01;
							oe_reg <= 1'b1;
							st_reg <= prtw_pkg::PRTW_WACK;
						end
					end
					prtw_pkg::PRTW_RD: begin
						if (cnt_reg == `PRTW_BITS_PER_BYTE) begin
							oe_reg <= 1'b0;
							ptr_reg <= ptr_reg + 8'h01;
							st_reg <= prtw_pkg::PRTW_RDACK;
						end else begin
							oe_reg <= ~shift_reg[6];
							shift_reg <= {shift_reg[6:0], 1'b0};
						end
					end
					prtw_pkg::PRTW_RDACK: begin
						cnt_reg <= 4'h0;
						if (mack_reg) begin
							shift_reg <= rd_byte;
							oe_reg <= ~rd_byte[7];
							st_reg <= prtw_pkg::PRTW_RD;
						end else begin
							st_reg <= prtw_pkg::PRTW_IDLE;
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	// Open-drain: only ever pull low
	assign sda_o = 1'b0;
	assign sda_oe_o = oe_reg;

	////////////////////////////////////////////////////////////////////////
	// Alarm window values
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pwnd_reg <= 16'h0000;
			twnd_reg <= `PRTW_REG_RESET;
		end else if (srst_reg) begin
			pwnd_reg <= 16'h0000;
			twnd_reg <= `PRTW_REG_RESET;
		end else if (wr_pls_reg) begin
			if (wr_addr_reg == `PRTW_ADDR_PWND_HI) begin
				pwnd_reg[15:8] <= wr_data_reg;
			end else if (wr_addr_reg == `PRTW_ADDR_PWND_LO) begin
				pwnd_reg[7:0] <= wr_data_reg;
			end else if (wr_addr_reg == `PRTW_ADDR_TWND) begin
				twnd_reg <= wr_data_reg;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Primary control; a reset request overrides the other fields
	assign ctrl_wr = wr_pls_reg && (wr_addr_reg == `PRTW_ADDR_CTRL) &&
		!wr_data_reg[`PRTW_CTRL_RST];

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			height_reg <= 1'b0;
			ovs_reg <= 3'h0;
			run_reg <= 1'b0;
		end else if (srst_reg) begin
			height_reg <= 1'b0;
			ovs_reg <= 3'h0;
			run_reg <= 1'b0;
		end else if (ctrl_wr) begin
			height_reg <= wr_data_reg[`PRTW_CTRL_HEIGHT];
			ovs_reg <= wr_data_reg[`PRTW_CTRL_OVS_HI:`PRTW_CTRL_OVS_LO];
			run_reg <= wr_data_reg[`PRTW_CTRL_RUN];
		end
	end

	// One-shot: self-clears only in standby; a host set wins over the clear
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			shot_reg <= 1'b0;
			start_reg <= 1'b0;
		end else if (srst_reg) begin
			shot_reg <= 1'b0;
			start_reg <= 1'b0;
		end else begin
			start_reg <= ctrl_wr && wr_data_reg[`PRTW_CTRL_SHOT] && !shot_reg;
			if (ctrl_wr) begin
				shot_reg <= wr_data_reg[`PRTW_CTRL_SHOT];
			end else if (shot_reg && !run_reg && meas_valid_i) begin
				shot_reg <= 1'b0;
			end
		end
	end

	// Software reset pulse; reads of the bit always return zero
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			srst_reg <= 1'b0;
		end else begin
			srst_reg <= wr_pls_reg && (wr_addr_reg == `PRTW_ADDR_CTRL) &&
				wr_data_reg[`PRTW_CTRL_RST];
		end
	end

	assign meas_start_o = start_reg;
	assign run_o = run_reg;
	assign awake_o = run_reg | shot_reg;
	assign height_mode_o = height_reg;
	assign oversample_o = ovs_reg;
	assign press_window_o = pwnd_reg;
	assign temp_window_o = twnd_reg;
	assign soft_reset_o = srst_reg;

	////////////////////////////////////////////////////////////////////////
	// Extreme capture slices; host write beats a same-cycle capture
	assign pmin_if.clr = srst_reg;
	assign pmin_if.smp_vld = meas_valid_i;
	assign pmin_if.smp = press_res_i;
	assign pmin_if.signed_cmp = height_reg;
	assign pmin_if.wr_en = wr_pls_reg && (wr_addr_reg >= `PRTW_ADDR_PMIN_H) &&
		(wr_addr_reg <= `PRTW_ADDR_PMIN_L);
	assign pmin_if.wr_idx = 2'(wr_addr_reg - `PRTW_ADDR_PMIN_H);
	assign pmin_if.wr_data = wr_data_reg;

	assign pmax_if.clr = srst_reg;
	assign pmax_if.smp_vld = meas_valid_i;
	assign pmax_if.smp = press_res_i;
	assign pmax_if.signed_cmp = height_reg;
	assign pmax_if.wr_en = wr_pls_reg && (wr_addr_reg >= `PRTW_ADDR_PMAX_H) &&
		(wr_addr_reg <= `PRTW_ADDR_PMAX_L);
	assign pmax_if.wr_idx = 2'(wr_addr_reg - `PRTW_ADDR_PMAX_H);
	assign pmax_if.wr_data = wr_data_reg;

	// Temperature is always signed, whatever the mode
	assign tmin_if.clr = srst_reg;
	assign tmin_if.smp_vld = meas_valid_i;
	assign tmin_if.smp = temp_res_i;
	assign tmin_if.signed_cmp = 1'b1;
	assign tmin_if.wr_en = wr_pls_reg && (wr_addr_reg >= `PRTW_ADDR_TMIN_H) &&
		(wr_addr_reg <= `PRTW_ADDR_TMIN_L);
	assign tmin_if.wr_idx = 2'(wr_addr_reg - `PRTW_ADDR_TMIN_H);
	assign tmin_if.wr_data = wr_data_reg;

	assign tmax_if.clr = srst_reg;
	assign tmax_if.smp_vld = meas_valid_i;
	assign tmax_if.smp = temp_res_i;
	assign tmax_if.signed_cmp = 1'b1;
	assign tmax_if.wr_en = wr_pls_reg && (wr_addr_reg >= `PRTW_ADDR_TMAX_H) &&
		(wr_addr_reg <= `PRTW_ADDR_TMAX_L);
	assign tmax_if.wr_idx = 2'(wr_addr_reg - `PRTW_ADDR_TMAX_H);
	assign tmax_if.wr_data = wr_data_reg;

	prtw_extreme #(.W(PRESS_W), .IS_MAX(1'b0)) u_pmin (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.c(pmin_if.cap)
	);

	prtw_extreme #(.W(PRESS_W), .IS_MAX(1'b1)) u_pmax (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.c(pmax_if.cap)
	);

	prtw_extreme #(.W(TEMP_W), .IS_MAX(1'b0)) u_tmin (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.c(tmin_if.cap)
	);

	prtw_extreme #(.W(TEMP_W), .IS_MAX(1'b1)) u_tmax (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.c(tmax_if.cap)
	);

endmodule // prtw_regs
`default_nettype wire

// [testbench/prtw_regs_sva.sv]
// Port-level assertions for the window, extreme and control register bank.
// Assumes SCL low phases of at least two mclk cycles from the host.
`timescale 1ns/100ps
`default_nettype none
module prtw_regs_sva (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic scl_i,
	input wire logic sda_oe_o,
	input wire logic meas_valid_i,
	input wire logic meas_start_o,
	input wire logic run_o,
	input wire logic awake_o,
	input wire logic height_mode_o,
	input wire logic [2:0] oversample_o,
	input wire logic [15:0] press_window_o,
	input wire logic [7:0] temp_window_o,
	input wire logic soft_reset_o
);
	// One clock domain, so one default for all
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_n_i);

	AST_RUN_AWAKE: assert property (run_o |-> awake_o)
		else $error("active without awake");
	AST_START_PULSE: assert property (meas_start_o |-> awake_o ##1 !meas_start_o)
		else $error("start pulse wrong");
	AST_ONESHOT_CLR: assert property ((meas_valid_i && !run_o && !meas_start_o) |=> !awake_o)
		else $error("one-shot not cleared");
	AST_START_CAUSE: assert property (meas_start_o |-> !scl_i && !$past(scl_i))
		else $error("start without host write");
	AST_SOFT_CLEAR: assert property (soft_reset_o |=> !run_o && !height_mode_o
		&& oversample_o == 3'h0 && press_window_o == 16'h0000 && temp_window_o == 8'h00)
		else $error("soft reset left state");
	AST_SOFT_PULSE: assert property (soft_reset_o |=> !soft_reset_o)
		else $error("soft reset too long");
	AST_MODE_HOLD: assert property ($changed(height_mode_o) |-> !$past(scl_i))
		else $error("mode moved without write");
	AST_PWND_HOLD: assert property (!$stable(press_window_o) |-> !$past(scl_i))
		else $error("window moved without write");
	AST_SDA_EDGE: assert property ($changed(sda_oe_o) |-> !scl_i)
		else $error("data changed with clock high");
endmodule // prtw_regs_sva
bind prtw_regs prtw_regs_sva i_sva (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .scl_i(scl_i),
	.sda_oe_o(sda_oe_o), .meas_valid_i(meas_valid_i), .meas_start_o(meas_start_o),
	.run_o(run_o), .awake_o(awake_o), .height_mode_o(height_mode_o),
	.oversample_o(oversample_o), .press_window_o(press_window_o),
	.temp_window_o(temp_window_o), .soft_reset_o(soft_reset_o));
`default_nettype wire

// [testbench/prtw_host_model.sv]
// Host controller model on the two-wire register port.
// Assumes sda_i is the resolved wire; a released line reads the pull-up.
`timescale 1ns/100ps
`default_nettype none
module prtw_host_model #(
	parameter logic [6:0] DEV = 7'h2a
) (
	input wire logic mclk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_drv_o
);
	// Idle bus: both lines released
	initial begin
		scl_o = 1'b1;
		sda_drv_o = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge mclk_i);
	endtask
	// Four mclk per phase keeps well above the two-cycle minimum
	task automatic clk_bit(output logic v);
		tick(2);
		scl_o <= 1'b1;
		tick(2);
		v = sda_i;
		tick(2);
		scl_o <= 1'b0;
		tick(2);
	endtask
	task automatic bus_start();
		sda_drv_o <= 1'b1;
		tick(2);
		scl_o <= 1'b1;
		tick(4);
		sda_drv_o <= 1'b0;
		tick(4);
		scl_o <= 1'b0;
		tick(2);
	endtask
	task automatic bus_stop();
		sda_drv_o <= 1'b0;
		tick(2);
		scl_o <= 1'b1;
		tick(4);
		sda_drv_o <= 1'b1;
		tick(4);
	endtask
	task automatic send_byte(input prtw_pkg::prtw_byte_t b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			sda_drv_o <= b[i];
			clk_bit(ack);
		end
		sda_drv_o <= 1'b1;
		clk_bit(ack);
		ack = !ack;
	endtask
	task automatic recv_byte(output prtw_pkg::prtw_byte_t b, input logic nack);
		logic v;
		sda_drv_o <= 1'b1;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(b[i]);
		end
		sda_drv_o <= nack;
		clk_bit(v);
	endtask
	task automatic addr_probe(input logic [6:0] a, output logic ack);
		bus_start();
		send_byte({a, 1'b0}, ack);
		bus_stop();
	endtask
	// Burst write from ptr upward
	task automatic write_regs(input prtw_pkg::prtw_byte_t ptr,
		input prtw_pkg::prtw_byte_t d[$], output logic ok);
		logic a;
		bus_start();
		send_byte({DEV, 1'b0}, ok);
		send_byte(ptr, a);
		ok = ok & a;
		foreach (d[i]) begin
			send_byte(d[i], a);
			ok = ok & a;
		end
		bus_stop();
	endtask
	// Pointer set, repeated start, burst read ended by NACK
	task automatic read_regs(input prtw_pkg::prtw_byte_t ptr, input int n,
		output prtw_pkg::prtw_byte_t q[$], output logic ok);
		logic a;
		prtw_pkg::prtw_byte_t b;
		q = {};
		bus_start();
		send_byte({DEV, 1'b0}, ok);
		send_byte(ptr, a);
		ok = ok & a;
		bus_start();
		send_byte({DEV, 1'b1}, a);
		ok = ok & a;
		for (int i = 0; i < n; i++) begin
			recv_byte(b, i == n - 1);
			q.push_back(b);
		end
		bus_stop();
	endtask
endmodule // prtw_host_model
`default_nettype wire

// [testbench/pressure_temp_window_minmax_regs_tb.sv]
// Self-checking bench for the register bank, driven through the host model.
// Assumes the measurement engine is played by the bench itself.
`timescale 1ns/100ps
`default_nettype none
module pressure_temp_window_minmax_regs_tb;
	typedef prtw_pkg::prtw_byte_t prtw_b_t;
	localparam logic [6:0] DEV = 7'h2a; // Arbitrary bus address
	logic mclk_i, rst_n_i, scl, sda_drv, sda_w, sda_oe, meas_valid, meas_start;
	logic run, awake, height, srst;
	logic [19:0] press;
	logic [11:0] temp;
	logic [2:0] ovs;
	logic [15:0] pwnd;
	logic [7:0] twnd;
	int num_errors = 0;
	int num_checks = 0;
	int starts = 0;
	int resets = 0;
	prtw_b_t zq[$];
	logic ok;
	////////////////////////////////////////////////////////////////////////
	// Open-drain wire: either party pulls low, else pull-up
	assign sda_w = sda_drv & ~sda_oe;
	prtw_regs i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda_w),
		.sda_o(), .sda_oe_o(sda_oe), .meas_valid_i(meas_valid), .press_res_i(press),
		.temp_res_i(temp), .meas_start_o(meas_start), .run_o(run), .awake_o(awake),
		.height_mode_o(height), .oversample_o(ovs), .press_window_o(pwnd),
		.temp_window_o(twnd), .soft_reset_o(srst));
	prtw_host_model #(.DEV(DEV)) i_host (.mclk_i(mclk_i), .sda_i(sda_w), .scl_o(scl),
		.sda_drv_o(sda_drv));
	initial begin
		mclk_i = 1'b0;
		forever #10 mclk_i = ~mclk_i;
	end
	// Count start and soft reset pulses; they last one cycle
	always @(posedge mclk_i) begin
		if (meas_start === 1'b1)
			starts++;
		if (srst === 1'b1)
			resets++;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk_byte(input prtw_b_t got, input prtw_b_t exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_port(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input prtw_b_t ptr, input prtw_b_t d[$]);
		i_host.write_regs(ptr, d, ok);
		chk_port({15'h0000, ok}, 16'h0001);
	endtask
	task automatic rd_chk(input prtw_b_t ptr, input prtw_b_t exp[$]);
		prtw_b_t q[$];
		i_host.read_regs(ptr, exp.size(), q, ok);
		chk_port({15'h0000, ok}, 16'h0001);
		foreach (exp[i])
			chk_byte(q[i], exp[i]);
	endtask
	// One completed result, a single-cycle pulse
	task automatic sample(input logic [19:0] p, input logic [11:0] t);
		meas_valid <= 1'b1;
		press <= p;
		temp <= t;
		@(posedge mclk_i);
		meas_valid <= 1'b0;
		repeat (2) @(posedge mclk_i);
	endtask
	initial begin
		repeat (60000) @(posedge mclk_i);
		num_errors++;
		complete_run();
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		rst_n_i = 1'b0;
		meas_valid = 1'b0;
		press = 20'h0_0000;
		temp = 12'h000;
		repeat (14) zq.push_back(8'h00);
		repeat (4) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		rd_chk(8'h19, zq);
		$display("Test reset done");
		wr(8'h19, '{8'ha5, 8'h3c, 8'h7e});
		chk_port(pwnd, 16'ha53c);
		chk_port({8'h00, twnd}, 16'h007e);
		rd_chk(8'h19, '{8'ha5, 8'h3c, 8'h7e});
		rd_chk(8'h30, '{8'h00});
		i_host.addr_probe(7'h2b, ok);
		chk_port({15'h0000, ok}, 16'h0000);
		$display("Test window done");
		sample(20'h0_0100, 12'h190);
		sample(20'h0_0085, 12'h203);
		sample(20'h0_0300, 12'h100);
		rd_chk(8'h1c, '{8'h00, 8'h08, 8'h50, 8'h10, 8'h00,
			8'h00, 8'h30, 8'h00, 8'h20, 8'h30});
		wr(8'h1e, '{8'hff});
		rd_chk(8'h1e, '{8'hf0});
		zq = zq[0:9];
		wr(8'h1c, zq);
		rd_chk(8'h1c, zq);
		$display("Test pressure extremes done");
		wr(8'h26, '{8'h80});
		chk_port({15'h0000, height}, 16'h0001);
		sample(20'hf_ff00, 12'hf80);
		sample(20'h0_0200, 12'h050);
		rd_chk(8'h1c, '{8'hff, 8'hf0, 8'h00, 8'hf8, 8'h00,
			8'h00, 8'h20, 8'h00, 8'h05, 8'h00});
		$display("Test height extremes done");
		wr(8'h26, '{8'h7a});
		chk_port({13'h0000, ovs}, 16'h0007);
		chk_port({15'h0000, awake}, 16'h0001);
		chk_port(16'(starts), 16'h0001);
		rd_chk(8'h26, '{8'h3a});
		sample(20'h0_0400, 12'h010);
		chk_port({15'h0000, awake}, 16'h0000);
		rd_chk(8'h26, '{8'h38});
		wr(8'h26, '{8'h39});
		chk_port({14'h0000, run, awake}, 16'h0003);
		wr(8'h26, '{8'h38});
		chk_port({15'h0000, run}, 16'h0000);
		$display("Test control done");
		i_host.write_regs(8'h26, '{8'h04}, ok);
		chk_port({pwnd[7:0], 5'h00, ovs}, 16'h0000);
		chk_port(16'(resets), 16'h0001);
		rd_chk(8'h19, '{8'h00, 8'h00, 8'h00});
		rd_chk(8'h1c, zq);
		$display("Test soft reset done");
		complete_run();
	end
endmodule // pressure_temp_window_minmax_regs_tb
`default_nettype wire
